// ===== msirq_map.svh
// Register offsets, field positions, reset values and counts of the motor sensor block
`ifndef MSIRQ_MAP_SVH
`define MSIRQ_MAP_SVH
`define MSIRQ_OFS_START    6'h00
`define MSIRQ_OFS_REGSEL   6'h04
`define MSIRQ_OFS_CTRL     6'h08
`define MSIRQ_OFS_OUTMODE  6'h0C
`define MSIRQ_OFS_ENV      6'h10
`define MSIRQ_OFS_RAMPDOWN 6'h14
`define MSIRQ_OFS_PORTWR   6'h18
`define MSIRQ_OFS_MAIN     6'h20
`define MSIRQ_OFS_EXT      6'h24
`define MSIRQ_OFS_PORTLVL  6'h28
`define MSIRQ_START_DIR    0
`define MSIRQ_START_HIGH   1
`define MSIRQ_START_STOPIE 5
`define MSIRQ_START_GO     6
`define MSIRQ_REGSEL_RDIE  4
`define MSIRQ_REGSEL_XSIE  5
`define MSIRQ_CTRL_ORG     0
`define MSIRQ_CTRL_SD      1
`define MSIRQ_CTRL_AUX     4
`define MSIRQ_OUT_MASK     2
`define MSIRQ_OUT_FILT     4
`define MSIRQ_ENV_LSTYLE   0
`define MSIRQ_ENV_OSTYLE   1
`define MSIRQ_ENV_AUTORD   2
`define MSIRQ_ENV_GPFUNC   3
`define MSIRQ_ENV_GPDIR    7:4
`define MSIRQ_ENV_COMPAT   9:8
`define MSIRQ_ENV_RESET    16'h0000
`define MSIRQ_FILT_CYCLES  4
`endif

// ===== msirq_pkg.sv
// Types shared by the motor sensor and interrupt block
package msirq_pkg;
    // Mechanical position inputs, all active low
    typedef struct packed {
        logic ext_stop_n;
        logic origin_n;
        logic minus_sd_n;
        logic plus_sd_n;
        logic minus_limit_n;
        logic plus_limit_n;
    } msirq_mech_t;
    // Commands toward the pulse generator
    typedef struct packed {
        logic start;
        logic dir_minus;
        logic high_speed;
        logic stop_now;
        logic stop_decel;
        logic slow_req;
        logic decel_point;
    } msirq_cmd_t;
    // Register access compatibility modes
    typedef enum logic [1:0] {
        MSIRQ_NATIVE,
        MSIRQ_LEGACY_A,
        MSIRQ_LEGACY_B,
        MSIRQ_RESVD
    } msirq_compat_t;
endpackage : msirq_pkg

// ===== msirq_core.sv
// Motor sensor inputs, interrupt causes, general-purpose pins and register slave
// Contract
// - Matching end limit low stops motion, immediate or decelerating; stays stopped.
// - Limit stop raises interrupt when started with stop interrupt enabled.
// - Start toward active limit or enabled origin is refused, interrupt still raised.
// - Pulse mask disables limit and origin control; levels stay readable.
// - Filter rejects pulses under 3 cycles, accepts over 4; off passes all.
// - One filter enable covers origin, both limits and external stop.
// - Slow-down control: matching input low decelerates, high accelerates again.
// - Slow-down low forces base speed start; ignored while decelerating.
// - Slow-down and origin levels always shown in extended status.
// - Origin return: origin low stops motion per style bit; stays stopped.
// - Three causes: stop, ramp-down point, external start, each own enable.
// - Enable 0 clears and blocks a cause; line active while any pending.
// - Main status bit per cause reads 0 while cause requests.
// - Extended status bit shows request output asserted, 0 when none.
// - Interrupt request is an open-drain output for wired-OR.
// - Ramp-down cause when remaining count at or below threshold.
// - Manual threshold is setting; only high-speed positioning decelerates there.
// - Aux output pin follows the control level bit.
// - Drive-type and step-resolution pin levels readable in port register.
// - Legacy modes make port register inaccessible.
// - Phase pins are sequence outputs after reset, general ports when selected.
// - Each port pin selectable in or out; actual level readable either way outside legacy modes.
`timescale 1ns/10ps
`default_nettype none
`include "msirq_map.svh"
module msirq_core #(
    parameter int CW = 24
) (
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    input  wire logic [5:0]           avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    input  wire logic [3:0]           avs_byteenable,
    output logic      [31:0]          avs_readdata,
    output logic                      avs_waitrequest,
    input  wire msirq_pkg::msirq_mech_t mech_in,
    input  wire logic                 motion_busy,
    input  wire logic                 motion_decel,
    input  wire logic                 motion_dir_minus,
    input  wire logic                 motion_high_pos,
    input  wire logic [CW-1:0]        remaining_pulse_counter,
    input  wire logic [CW-1:0]        auto_threshold,
    input  wire logic                 ext_start_pulse,
    input  wire logic [3:0]           phase_outputs,
    output msirq_pkg::msirq_cmd_t     cmd_out,
    output logic                      irq_n_out,
    output logic                      irq_n_oe,
    output logic                      aux_output_pin,
    input  wire logic                 drive_type_pin,
    input  wire logic                 step_res_pin,
    input  wire logic [3:0]           gp_port_pins_in,
    output logic      [3:0]           gp_port_pins_out,
    output logic      [3:0]           gp_port_pins_oe
);
    import msirq_pkg::*;

    localparam int NM = 6;
    localparam int FN = `MSIRQ_FILT_CYCLES;

    logic [NM-1:0]  mech_s1_ff;
    logic [NM-1:0]  mech_s2_ff;
    logic [NM-1:0]  mech_flt_ff;
    logic [NM-1:0]  mech_use;
    logic [5:0]     pin_s1_ff;
    logic [5:0]     pin_s2_ff;
    logic [7:0]     start_ff;
    logic [7:0]     regsel_ff;
    logic [7:0]     ctrl_ff;
    logic [7:0]     outmode_ff;
    logic [15:0]    env_ff;
    logic [CW-1:0]  rampdown_setting_ff;
    logic [3:0]     gp_level_ff;
    logic           ack_ff;
    logic [31:0]    rdata_ff;
    logic [2:0]     pend_ff;
    logic           busy_d_ff;
    msirq_cmd_t     cmd_ff;
    logic           wr_acc;
    logic           start_go;
    logic           legacy;
    logic           masked;
    logic           plus_lim;
    logic           minus_lim;
    logic           plus_sd;
    logic           minus_sd;
    logic           org_low;
    logic           lim_match;
    logic           sd_match;
    logic           org_stop;
    logic           start_blocked;
    logic           refused;
    logic [CW-1:0]  rampdown_threshold;
    logic           below_thr;
    logic [2:0]     cause_set;
    logic [2:0]     cause_en;
    logic [15:0]    ext_status;
    logic [7:0]     port_level;
    logic [31:0]    env_merged;
    logic [31:0]    rd_merged;

    // Merge write data into a register under the byte enables
    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction : be_merge

    // Byte-lane merges, formed apart because a call result cannot be sliced
    assign env_merged = be_merge({16'h0000, env_ff}, avs_writedata, avs_byteenable);
    assign rd_merged  = be_merge(32'(rampdown_setting_ff), avs_writedata, avs_byteenable);

    // Two-stage synchronisers for every pin input
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mech_s1_ff <= '1;
            mech_s2_ff <= '1;
            pin_s1_ff  <= '0;
            pin_s2_ff  <= '0;
        end
        else
        begin
            mech_s1_ff <= mech_in;
            mech_s2_ff <= mech_s1_ff;
            pin_s1_ff  <= {step_res_pin, drive_type_pin, gp_port_pins_in};
            pin_s2_ff  <= pin_s1_ff;
        end
    end

    // Noise filter: a level is taken once stable for FN samples
    // Slow-down inputs bypass it; one enable for the other four
    for (genvar g = 0; g < NM; g++)
    begin : g_filt
        logic [FN-2:0] hist_ff;
        always_ff @(posedge clk or negedge reset_n)
        begin
            if (!reset_n)
            begin
                hist_ff       <= '1;
                mech_flt_ff[g] <= 1'b1;
            end
            else
            begin
                hist_ff <= {hist_ff[FN-3:0], mech_s2_ff[g]};
                if (&{hist_ff, mech_s2_ff[g]})
                    mech_flt_ff[g] <= 1'b1;
                else if (~|{hist_ff, mech_s2_ff[g]})
                    mech_flt_ff[g] <= 1'b0;
            end
        end
        if (g == 2 || g == 3)
        begin : g_raw
            assign mech_use[g] = mech_s2_ff[g];
        end
        else
        begin : g_sel
            // Shared filter enable
            assign mech_use[g] = outmode_ff[`MSIRQ_OUT_FILT] ? mech_flt_ff[g] : mech_s2_ff[g];
        end
    end

    // Active-high views of the conditioned inputs
    assign plus_lim  = ~mech_use[0];
    assign minus_lim = ~mech_use[1];
    assign plus_sd   = ~mech_use[2];
    assign minus_sd  = ~mech_use[3];
    assign org_low   = ~mech_use[4];
    assign masked    = outmode_ff[`MSIRQ_OUT_MASK];
    assign legacy    = (msirq_compat_t'(env_ff[`MSIRQ_ENV_COMPAT]) != MSIRQ_NATIVE);

    // Avalon slave: one wait state; read data registered at the waiting edge, write taken at the released edge
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
    assign wr_acc          = avs_write & ack_ff;
    assign avs_readdata    = rdata_ff;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            ack_ff <= 1'b0;
        else
            ack_ff <= (avs_read | avs_write) & ~ack_ff;
    end

    // Writable registers; a legacy mode hides the port register
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            start_ff            <= 8'h00;
            regsel_ff           <= 8'h00;
            ctrl_ff             <= 8'h00;
            outmode_ff          <= 8'h00;
            env_ff              <= `MSIRQ_ENV_RESET;
            rampdown_setting_ff <= '0;
            gp_level_ff         <= 4'h0;
        end
        else if (wr_acc && avs_byteenable[0])
        begin
            unique case (avs_address)
                `MSIRQ_OFS_START:   start_ff   <= avs_writedata[7:0];
                `MSIRQ_OFS_REGSEL:  regsel_ff  <= avs_writedata[7:0];
                `MSIRQ_OFS_CTRL:    ctrl_ff    <= avs_writedata[7:0];
                `MSIRQ_OFS_OUTMODE: outmode_ff <= avs_writedata[7:0];
                `MSIRQ_OFS_ENV:
                    env_ff <= env_merged[15:0];
                `MSIRQ_OFS_RAMPDOWN:
                    rampdown_setting_ff <= rd_merged[CW-1:0];
                `MSIRQ_OFS_PORTWR:
                    if (!legacy)
                        gp_level_ff <= avs_writedata[3:0];
                default: ;
            endcase
        end
    end

    // Status words
    assign ext_status = {10'h000, |pend_ff, mech_use[4], minus_sd ? 1'b1 : 1'b0,
                         plus_sd ? 1'b1 : 1'b0, minus_lim, plus_lim};
    assign port_level = legacy ? 8'h00 : {2'b00, pin_s2_ff};

    // Registered read data; unmapped offsets read zero
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            rdata_ff <= 32'h0000_0000;
        else if (avs_read && !ack_ff)
        begin
            unique case (avs_address)
                `MSIRQ_OFS_ENV:      rdata_ff <= {16'h0000, env_ff};
                `MSIRQ_OFS_RAMPDOWN: rdata_ff <= 32'(rampdown_setting_ff);
                `MSIRQ_OFS_MAIN:     rdata_ff <= {29'h0, ~pend_ff};
                `MSIRQ_OFS_EXT:      rdata_ff <= {16'h0000, ext_status};
                `MSIRQ_OFS_PORTLVL:  rdata_ff <= {24'h000000, port_level};
                default:             rdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // Direction-matched conditions; mask disables limit and origin control
    assign lim_match = ~masked & (motion_dir_minus ? minus_lim : plus_lim);
    assign org_stop  = ~masked & ctrl_ff[`MSIRQ_CTRL_ORG] & org_low;
    assign sd_match  = ctrl_ff[`MSIRQ_CTRL_SD] & (motion_dir_minus ? minus_sd : plus_sd);
    assign start_go  = wr_acc & avs_byteenable[0] & (avs_address == `MSIRQ_OFS_START)
                       & avs_writedata[`MSIRQ_START_GO];
    assign start_blocked = ~masked & ((avs_writedata[`MSIRQ_START_DIR] ? minus_lim : plus_lim)
                           | (ctrl_ff[`MSIRQ_CTRL_ORG] & org_low));
    assign refused   = start_go & start_blocked;

    // Threshold source and comparison
    assign rampdown_threshold = env_ff[`MSIRQ_ENV_AUTORD] ? auto_threshold : rampdown_setting_ff;
    assign below_thr          = remaining_pulse_counter <= rampdown_threshold;

    // Motion commands, registered
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            cmd_ff <= '0;
        else
        begin
            cmd_ff.start      <= start_go & ~start_blocked;
            cmd_ff.dir_minus  <= start_go ? avs_writedata[`MSIRQ_START_DIR] : cmd_ff.dir_minus;
            cmd_ff.high_speed <= start_go ? (avs_writedata[`MSIRQ_START_HIGH]
                                 & ~(ctrl_ff[`MSIRQ_CTRL_SD]
                                 & (avs_writedata[`MSIRQ_START_DIR] ? minus_sd : plus_sd)))
                                 : cmd_ff.high_speed;
            cmd_ff.stop_now   <= motion_busy & ((lim_match & ~env_ff[`MSIRQ_ENV_LSTYLE])
                                 | (org_stop & ~env_ff[`MSIRQ_ENV_OSTYLE]));
            cmd_ff.stop_decel <= motion_busy & ((lim_match & env_ff[`MSIRQ_ENV_LSTYLE])
                                 | (org_stop & env_ff[`MSIRQ_ENV_OSTYLE]));
            cmd_ff.slow_req   <= motion_busy & sd_match & ~motion_decel;
            cmd_ff.decel_point <= motion_busy & motion_high_pos & below_thr;
        end
    end
    assign cmd_out = cmd_ff;

    // Cause detection; stop-after-limit holds until the pulse generator stops
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            busy_d_ff <= 1'b0;
        else
            busy_d_ff <= motion_busy;
    end
    assign cause_en  = {regsel_ff[`MSIRQ_REGSEL_XSIE], regsel_ff[`MSIRQ_REGSEL_RDIE],
                        start_ff[`MSIRQ_START_STOPIE]};
    // A refused start uses the enable carried by that same command
    assign cause_set = {cause_en[2] & ext_start_pulse, cause_en[1] & motion_busy & below_thr,
                        (cause_en[0] & busy_d_ff & ~motion_busy)
                        | (refused & avs_writedata[`MSIRQ_START_STOPIE])};

    // Pending causes: set wins over the clear by a zero enable
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            pend_ff <= 3'b000;
        else
            pend_ff <= cause_set | (pend_ff & cause_en);
    end

    // Open drain request: only ever pulls low
    assign irq_n_out = 1'b0;
    assign irq_n_oe  = |pend_ff;

    // Aux output and phase pin function select
    assign aux_output_pin = ctrl_ff[`MSIRQ_CTRL_AUX];
    always_comb
    begin
        if (env_ff[`MSIRQ_ENV_GPFUNC])
        begin
            gp_port_pins_out = gp_level_ff;
            gp_port_pins_oe  = ~env_ff[`MSIRQ_ENV_GPDIR];
        end
        else
        begin
            gp_port_pins_out = phase_outputs;
            gp_port_pins_oe  = 4'hF;
        end
    end

    // Checks
    property p_limit_stop;
        @(posedge clk) disable iff (!reset_n)
        (motion_busy && lim_match && !env_ff[`MSIRQ_ENV_LSTYLE]) |=> cmd_ff.stop_now;
    endproperty
    a_limit_stop: assert property (p_limit_stop) else $error("limit did not stop");
    property p_refuse;
        @(posedge clk) disable iff (!reset_n)
        refused |=> !cmd_ff.start && (pend_ff[0] || !start_ff[`MSIRQ_START_STOPIE]);
    endproperty
    a_refuse: assert property (p_refuse) else $error("blocked start issued");
    property p_mask;
        @(posedge clk) disable iff (!reset_n)
        (masked && !$past(masked)) ##1 masked |-> !cmd_ff.stop_now && !cmd_ff.stop_decel;
    endproperty
    a_mask: assert property (p_mask) else $error("masked input stopped motion");
    property p_filter_short;
        @(posedge clk) disable iff (!reset_n)
        (outmode_ff[`MSIRQ_OUT_FILT] && $fell(mech_s2_ff[0]) && mech_flt_ff[0]) ##1
        !mech_s2_ff[0] ##1 !mech_s2_ff[0] ##1 mech_s2_ff[0] |-> mech_flt_ff[0] [*3];
    endproperty
    a_filter_short: assert property (p_filter_short) else $error("glitch passed");
    property p_filter_long;
        @(posedge clk) disable iff (!reset_n)
        (!mech_s2_ff[0]) [*4] |=> !mech_flt_ff[0];
    endproperty
    a_filter_long: assert property (p_filter_long) else $error("long pulse lost");
    property p_slow;
        @(posedge clk) disable iff (!reset_n)
        (motion_busy && sd_match && !motion_decel) |=> cmd_ff.slow_req;
    endproperty
    a_slow: assert property (p_slow) else $error("no slow request");
    property p_clear;
        @(posedge clk) disable iff (!reset_n)
        (!cause_en[1] && !cause_en[0] && !cause_en[2]) [*2] |-> !irq_n_oe;
    endproperty
    a_clear: assert property (p_clear) else $error("request not released");
    property p_set;
        @(posedge clk) disable iff (!reset_n) (|cause_set) |=> irq_n_oe && ext_status[5];
    endproperty
    a_set: assert property (p_set) else $error("cause not flagged");
    property p_main;
        @(posedge clk) disable iff (!reset_n)
        (avs_read && !ack_ff && avs_address == `MSIRQ_OFS_MAIN) |=>
        avs_readdata[2:0] == ~$past(pend_ff);
    endproperty
    a_main: assert property (p_main) else $error("main status wrong");
    property p_legacy;
        @(posedge clk) disable iff (!reset_n)
        (avs_read && !ack_ff && legacy && avs_address == `MSIRQ_OFS_PORTLVL) |=>
        avs_readdata == 32'h0000_0000;
    endproperty
    a_legacy: assert property (p_legacy) else $error("port reg visible");
    c_limit: cover property (@(posedge clk) disable iff (!reset_n) cmd_ff.stop_decel);
    c_refuse: cover property (@(posedge clk) disable iff (!reset_n) refused);
    c_irq: cover property (@(posedge clk) disable iff (!reset_n) $fell(irq_n_oe));
endmodule : msirq_core
`default_nettype wire

// ===== msirq_mech_model.sv
// Mechanical position switch model: limits, slow-down, origin and external stop
`timescale 1ns/10ps
`default_nettype none
module msirq_mech_model (
    input  wire logic [5:0]            closed,
    output wire msirq_pkg::msirq_mech_t mech
);
    import msirq_pkg::*;
    // Pulled-up contacts: open reads high, closed pulls the line low
    assign mech = msirq_mech_t'(~closed);
endmodule : msirq_mech_model
`default_nettype wire

// ===== msirq_core_tb_top.sv
// Self-checking testbench of the motor sensor and interrupt block
`timescale 1ns/10ps
`default_nettype none
module msirq_core_tb_top;
    import msirq_pkg::*;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [5:0]  adr = 6'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdat;
    logic        wreq;
    msirq_mech_t mech;
    logic [5:0]  closed = 6'h00;
    logic        busy = 1'b0;
    logic        dcl = 1'b0;
    logic        hp = 1'b0;
    logic [23:0] cnt = 24'h0;
    logic        xs = 1'b0;
    logic [3:0]  ph = 4'h9;
    msirq_cmd_t  cmd;
    logic        irq_o;
    logic        irq_oe;
    logic        aux;
    logic        dt = 1'b0;
    logic        sr = 1'b1;
    logic [3:0]  gpi;
    logic [3:0]  gpo;
    logic [3:0]  goe;
    logic [31:0] q;
    int          fail_count = 0;
    int          compares = 0;
    int          starts = 0;
    int          stops = 0;

    always #2.5 clk = ~clk;
    // Port pins carry a pull-down, so undriven pins read low
    assign gpi = goe & gpo;

    msirq_mech_model u_msirq_mech_model (.closed(closed), .mech(mech));
    msirq_core u_msirq_core (
        .clk(clk), .reset_n(reset_n), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdat),
        .avs_waitrequest(wreq), .mech_in(mech), .motion_busy(busy), .motion_decel(dcl),
        .motion_dir_minus(1'b0), .motion_high_pos(hp), .remaining_pulse_counter(cnt),
        .auto_threshold(24'h0), .ext_start_pulse(xs), .phase_outputs(ph), .cmd_out(cmd),
        .irq_n_out(irq_o), .irq_n_oe(irq_oe), .aux_output_pin(aux), .drive_type_pin(dt),
        .step_res_pin(sr), .gp_port_pins_in(gpi), .gp_port_pins_out(gpo),
        .gp_port_pins_oe(goe)
    );

    // Count start pulses and cycles of either stop request
    always @(posedge clk)
    begin
        if (cmd.start === 1'b1)
            starts++;
        if (cmd.stop_now === 1'b1 || cmd.stop_decel === 1'b1)
            stops++;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            fail_count++;
        end
    endtask : chk

    // One Avalon transfer; request held until a rising edge samples waitrequest low
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= ~w;
        @(posedge clk);
        while (wreq !== 1'b0)
            @(posedge clk);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus

    task automatic t_status;
        closed <= 6'h1F;
        cyc(6);
        bus(1'b0, 6'h24, 32'h0);
        chk("ext levels", q[5:0], 6'h0F);
        closed <= 6'h00;
        cyc(6);
        bus(1'b0, 6'h24, 32'h0);
        chk("ext idle", q[5:0], 6'h10);
        bus(1'b0, 6'h20, 32'h0);
        chk("main idle", q[2:0], 3'b111);
        $display("status test done");
    endtask : t_status

    task automatic t_port;
        chk("phase out", gpo, ph);
        chk("phase oe", goe, 4'hF);
        dt <= 1'b1;
        sr <= 1'b0;
        bus(1'b1, 6'h10, 32'h58);
        bus(1'b1, 6'h18, 32'h0F);
        cyc(6);
        chk("gp oe", goe, 4'hA);
        bus(1'b0, 6'h28, 32'h0);
        chk("port level", q[5:0], 6'h1A);
        bus(1'b1, 6'h10, 32'h158);
        bus(1'b0, 6'h28, 32'h0);
        chk("legacy port", q, 32'h0);
        bus(1'b0, 6'h3C, 32'h0);
        chk("unmapped", q, 32'h0);
        bus(1'b1, 6'h10, 32'h0);
        bus(1'b1, 6'h08, 32'h10);
        cyc(1);
        chk("aux high", aux, 1'b1);
        chk("irq drive low", irq_o, 1'b0);
        bus(1'b1, 6'h08, 32'h0);
        cyc(1);
        chk("aux low", aux, 1'b0);
        $display("port test done");
    endtask : t_port

    task automatic t_limit(input logic dc);
        int s0;
        s0 = starts;
        bus(1'b1, 6'h10, {31'h0, dc});
        bus(1'b1, 6'h00, 32'h60);
        cyc(2);
        chk("start", starts - s0, 1);
        busy <= 1'b1;
        closed <= 6'h02;
        cyc(8);
        chk("stop other dir", {cmd.stop_now, cmd.stop_decel}, 2'b00);
        closed <= 6'h01;
        cyc(8);
        chk("stop kind", {cmd.stop_now, cmd.stop_decel}, {~dc, dc});
        busy <= 1'b0;
        cyc(3);
        chk("stop irq", irq_oe, 1'b1);
        bus(1'b0, 6'h20, 32'h0);
        chk("main stop", q[2:0], 3'b110);
        bus(1'b0, 6'h24, 32'h0);
        chk("ext irq", q[5], 1'b1);
        bus(1'b1, 6'h00, 32'h0);
        cyc(2);
        chk("stop clear", irq_oe, 1'b0);
        closed <= 6'h00;
        $display("limit test done");
    endtask : t_limit

    task automatic t_refuse;
        int s0;
        s0 = starts;
        closed <= 6'h01;
        cyc(6);
        bus(1'b1, 6'h00, 32'h60);
        cyc(3);
        chk("refused", starts - s0, 0);
        chk("refused irq", irq_oe, 1'b1);
        bus(1'b1, 6'h00, 32'h41);
        cyc(3);
        chk("minus start", starts - s0, 1);
        chk("irq blocked", irq_oe, 1'b0);
        bus(1'b1, 6'h0C, 32'h04);
        bus(1'b1, 6'h00, 32'h40);
        cyc(3);
        chk("masked start", starts - s0, 2);
        bus(1'b0, 6'h24, 32'h0);
        chk("masked level", q[1:0], 2'b01);
        bus(1'b1, 6'h0C, 32'h0);
        closed <= 6'h10;
        bus(1'b1, 6'h08, 32'h01);
        cyc(3);
        busy <= 1'b1;
        cyc(8);
        chk("origin stop", cmd.stop_now, 1'b1);
        busy <= 1'b0;
        s0 = starts;
        bus(1'b1, 6'h00, 32'h40);
        cyc(3);
        chk("origin refuse", starts - s0, 0);
        bus(1'b1, 6'h08, 32'h0);
        closed <= 6'h00;
        $display("refuse and origin test done");
    endtask : t_refuse

    // Limit pulse of n cycles while moving; pass says if a stop must follow
    task automatic pulse(input int n, input logic pass);
        int s0;
        s0 = stops;
        closed <= 6'h01;
        cyc(n);
        closed <= 6'h00;
        cyc(10);
        chk("filter", stops != s0, pass);
    endtask : pulse

    task automatic t_filter;
        bus(1'b1, 6'h0C, 32'h10);
        busy <= 1'b1;
        pulse(3, 1'b0);
        pulse(5, 1'b1);
        bus(1'b1, 6'h0C, 32'h0);
        pulse(3, 1'b1);
        bus(1'b1, 6'h08, 32'h02);
        closed <= 6'h08;
        cyc(8);
        chk("slow other", cmd.slow_req, 1'b0);
        closed <= 6'h04;
        cyc(8);
        chk("slow on", cmd.slow_req, 1'b1);
        dcl <= 1'b1;
        cyc(2);
        chk("slow in decel", cmd.slow_req, 1'b0);
        dcl <= 1'b0;
        bus(1'b1, 6'h00, 32'h42);
        cyc(1);
        chk("base speed", cmd.high_speed, 1'b0);
        closed <= 6'h00;
        cyc(8);
        chk("slow off", cmd.slow_req, 1'b0);
        bus(1'b1, 6'h00, 32'h42);
        cyc(1);
        chk("high speed", cmd.high_speed, 1'b1);
        busy <= 1'b0;
        bus(1'b1, 6'h08, 32'h0);
        $display("filter and slow-down test done");
    endtask : t_filter

    task automatic t_irq;
        bus(1'b1, 6'h14, 32'h05);
        bus(1'b1, 6'h04, 32'h10);
        cnt <= 24'h6;
        busy <= 1'b1;
        hp <= 1'b1;
        cyc(4);
        chk("ramp above", irq_oe, 1'b0);
        chk("decel above", cmd.decel_point, 1'b0);
        cnt <= 24'h5;
        cyc(4);
        chk("ramp equal", irq_oe, 1'b1);
        chk("decel equal", cmd.decel_point, 1'b1);
        bus(1'b0, 6'h20, 32'h0);
        chk("main ramp", q[2:0], 3'b101);
        bus(1'b1, 6'h04, 32'h0);
        cyc(2);
        chk("ramp clear", irq_oe, 1'b0);
        busy <= 1'b0;
        bus(1'b1, 6'h04, 32'h20);
        xs <= 1'b1;
        cyc(1);
        xs <= 1'b0;
        cyc(3);
        chk("ext start irq", irq_oe, 1'b1);
        bus(1'b0, 6'h20, 32'h0);
        chk("main ext", q[2:0], 3'b011);
        bus(1'b1, 6'h04, 32'h0);
        xs <= 1'b1;
        cyc(1);
        xs <= 1'b0;
        cyc(3);
        chk("ext blocked", irq_oe, 1'b0);
        $display("interrupt test done");
    endtask : t_irq

    task automatic end_sim;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim

    // Main sequence after eight cycles of reset
    initial
    begin
        cyc(8);
        reset_n <= 1'b1;
        t_port;
        t_status;
        t_limit(1'b0);
        t_limit(1'b1);
        t_refuse;
        t_filter;
        t_irq;
        end_sim;
    end

    // Tests take about 320 cycles; the watchdog allows over sixty times that
    initial
    begin
        #100000;
        fail_count++;
        end_sim;
    end
endmodule : msirq_core_tb_top
`default_nettype wire
